// file: src/sscar_pkg.sv
// Package with the register map, field layout and address constants of the sound router.
package sscar_pkg;
  localparam logic [15:0] CFG_ADDR = 16'hD0F4;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int PHYS_LSB = 3;
  localparam int EMU_LSB = 0;
  localparam logic [15:0] PAGE_D4 = 16'hD400;
  localparam logic [15:0] PAGE_D5 = 16'hD500;
  localparam logic [15:0] PAGE_D7 = 16'hD700;
  localparam logic [15:0] PAGE_DE = 16'hDE00;
  localparam logic [15:0] PAGE_DF = 16'hDF00;
  localparam logic [15:0] BASE_D420 = 16'hD420;
  localparam int SOUND_SEL_BIT = 5;
  localparam int PAGE_SEL_BIT = 8;
  localparam logic [4:0] REG_IDX_MASK = 5'h1F;
  typedef enum logic [2:0] {
    PHYS_SINGLE = 3'h0,
    PHYS_D420 = 3'h1,
    PHYS_RSVD = 3'h2,
    PHYS_RSVD3 = 3'h3,
    PHYS_D500 = 3'h4,
    PHYS_D700 = 3'h5,
    PHYS_DE00 = 3'h6,
    PHYS_DF00 = 3'h7
  } sscar_phys_t;
  typedef enum logic [2:0] {
    EMU_SINGLE = 3'h0,
    EMU_ADDR5 = 3'h1,
    EMU_RSVD = 3'h2,
    EMU_RSVD3 = 3'h3,
    EMU_ADDR8 = 3'h4,
    EMU_ADDR8_ALT = 3'h5,
    EMU_IO1 = 3'h6,
    EMU_IO2 = 3'h7
  } sscar_emu_t;
endpackage

// file: src/sscar_dec_if.sv
// Interface carrying an access and its decode result between the router and its decoder.
`timescale 1ns/1ps
interface sscar_dec_if;
  logic [15:0] addr;
  logic [2:0] emu_code;
  logic d7_area_on;
  logic cart_io1_on;
  logic cart_io2_on;
  logic first_hit;
  logic second_hit;
  modport router (output addr, output emu_code, output d7_area_on, output cart_io1_on,
                  output cart_io2_on, input first_hit, input second_hit);
  modport decoder (input addr, input emu_code, input d7_area_on, input cart_io1_on,
                   input cart_io2_on, output first_hit, output second_hit);
endinterface

// file: src/sscar_emu_decode.sv
// Decoder that places the two emulated generators in the host address space.
`timescale 1ns/1ps
module sscar_emu_decode
  import sscar_pkg::*;
(
  sscar_dec_if.decoder dec // Access to decode and its result.
);
  logic in_sound;
  logic in_d7;
  logic in_de;
  logic in_df;
  logic stereo;

  assign in_sound = dec.addr[15:10] == PAGE_D4[15:10];
  assign in_d7 = dec.addr[15:8] == PAGE_D7[15:8];
  assign in_de = dec.addr[15:8] == PAGE_DE[15:8];
  assign in_df = dec.addr[15:8] == PAGE_DF[15:8];
  // Reserved codes decode as single, so nothing new appears in the map.
  assign stereo = !(dec.emu_code inside {EMU_SINGLE, EMU_RSVD, EMU_RSVD3});

  always_comb begin
    dec.second_hit = 1'b0;
    if (stereo) begin
      unique case (dec.emu_code)
        EMU_ADDR5: dec.second_hit = in_sound && dec.addr[SOUND_SEL_BIT];
        EMU_ADDR8, EMU_ADDR8_ALT: dec.second_hit = in_sound && dec.addr[PAGE_SEL_BIT];
        EMU_IO1: dec.second_hit = in_de && !dec.cart_io1_on;
        EMU_IO2: dec.second_hit = in_df && !dec.cart_io2_on;
        default: dec.second_hit = 1'b0;
      endcase
    end
    // The extra memory area at D7xx takes the access before any generator.
    if (in_d7 && dec.d7_area_on) begin
      dec.second_hit = 1'b0;
    end
  end

  // The first generator keeps the rest of the sound area in every setting, except D7xx while the memory area there is enabled.
  assign dec.first_hit = in_sound && !dec.second_hit && !(in_d7 && dec.d7_area_on);
endmodule // sscar_emu_decode

// file: src/sscar_router.sv
// Top of the sound router: configuration register, write routing and audio mapping.
//
// Contract
// - Stereo with one real chip: only left-channel writes reach that chip.
// - Two real chips active: left writes to first, right writes to second.
// - Real second chip address is translated independently of the emulated address.
// - Cartridge expansion I/O pages win over a second generator mapped there.
// - Bits 5..3 choose the real second chip location; 010 reserved.
// - Bits 2..0 choose single or stereo emulation and second generator decoding.
// - Code 001 selects second generator by address bit 5 in D4xx.
// - The first expansion select setting puts the second generator at DE00.
// - The second expansion select setting puts the second generator at DF00.
// - Single emulation plays the generator on both outputs as mono.
// - Stereo settings keep the first generator at D400 on left output.
// - Stereo settings play the second generator on the right output.
// - An enabled D700 memory area wins over a second generator there.
`timescale 1ns/1ps
module sscar_router
  import sscar_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter logic [7:0] CFG_INIT = CFG_RESET
) (
  input wire logic CLK, // System clock, 20 MHz.
  input wire logic RESET, // Asynchronous reset, active high.
  input wire logic [15:0] ADDR, // Host bus address.
  input wire logic [7:0] WDATA, // Host bus write data.
  input wire logic WR, // Write strobe, one cycle.
  input wire logic RD, // Read strobe, one cycle.
  input wire logic CFG_MODE, // Configuration registers visible.
  input wire logic D7_AREA_ON, // Extra memory at D7xx enabled.
  input wire logic CART_IO1_ON, // Cartridge emulation owns DExx.
  input wire logic CART_IO2_ON, // Cartridge emulation owns DFxx.
  input wire logic [SAMPLE_W-1:0] GEN0_SAMPLE, // First emulated generator output.
  input wire logic [SAMPLE_W-1:0] GEN1_SAMPLE, // Second emulated generator output.
  output logic [7:0] RDATA, // Configuration read data.
  output logic RDATA_VALID, // Read data valid, one cycle.
  output logic [7:0] CFG, // Current configuration value.
  output logic GEN0_WR, // Write pulse to first generator.
  output logic GEN1_WR, // Write pulse to second generator.
  output logic [4:0] GEN_REG, // Generator register index.
  output logic [7:0] GEN_DATA, // Generator write data.
  output logic CHIP0_WR, // Write pulse to first real chip.
  output logic CHIP1_WR, // Write pulse to second real chip.
  output logic [15:0] CHIP_ADDR, // Translated bus address for a real chip.
  output logic [7:0] CHIP_DATA, // Real chip write data.
  output logic FIRST_EXPANSION_IO_SELECT, // Second chip select on DExx line.
  output logic SECOND_EXPANSION_IO_SELECT, // Second chip select on DFxx line.
  output logic [SAMPLE_W-1:0] AUDIO_LEFT, // Left audio output.
  output logic [SAMPLE_W-1:0] AUDIO_RIGHT // Right audio output.
);
  // Refuse a sample width that leaves no bits to carry audio.
  if (SAMPLE_W < 1) begin : g_bad_width
    $error("SAMPLE_W must be at least 1");
  end

  logic [7:0] sound_emulation_config;
  logic [2:0] phys_code;
  logic [2:0] emu_code;
  logic emu_stereo;
  logic phys_valid;
  logic [15:0] phys_base;
  logic cfg_hit;
  logic [4:0] reg_idx;
  logic left_wr;
  logic right_wr;
  logic right_to_chip;

  sscar_dec_if dec ();
  sscar_emu_decode u_dec (
    .dec(dec)
  );

  assign phys_code = sound_emulation_config[PHYS_LSB +: 3];
  assign emu_code = sound_emulation_config[EMU_LSB +: 3];
  assign emu_stereo = !(emu_code inside {EMU_SINGLE, EMU_RSVD, EMU_RSVD3});
  assign phys_valid = !(phys_code inside {PHYS_SINGLE, PHYS_RSVD, PHYS_RSVD3});
  assign cfg_hit = CFG_MODE && (ADDR == CFG_ADDR);
  assign reg_idx = ADDR[4:0] & REG_IDX_MASK;

  // A left-channel write is any write that the first generator decodes.
  assign left_wr = WR && dec.first_hit;
  assign right_wr = WR && dec.second_hit;
  // A right write only reaches a real chip when one is fitted and stereo is on.
  assign right_to_chip = right_wr && emu_stereo && phys_valid;

  assign dec.addr = ADDR;
  assign dec.emu_code = emu_code;
  assign dec.d7_area_on = D7_AREA_ON;
  assign dec.cart_io1_on = CART_IO1_ON;
  assign dec.cart_io2_on = CART_IO2_ON;

  // Bus location of the real second chip, unrelated to the emulated location.
  always_comb begin
    phys_base = BASE_D420;
    unique case (phys_code)
      PHYS_D500: phys_base = PAGE_D5;
      PHYS_D700: phys_base = PAGE_D7;
      PHYS_DE00: phys_base = PAGE_DE;
      PHYS_DF00: phys_base = PAGE_DF;
      default: phys_base = BASE_D420;
    endcase
  end

  // Bits 7 and 6 are stored as written; software keeps them zero.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sound_emulation_config <= CFG_INIT;
    end else if (WR && cfg_hit) begin
      sound_emulation_config <= WDATA;
    end
  end

  // Read data is held until the next read hit, so software may pick it up late.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (RD && cfg_hit) begin
      RDATA <= sound_emulation_config;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= RD && cfg_hit;
    end
  end

  // Emulated generator write pulses.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      GEN0_WR <= 1'b0;
      GEN1_WR <= 1'b0;
    end else begin
      GEN0_WR <= left_wr;
      GEN1_WR <= right_wr;
    end
  end

  // Register index and data of the last write, shared by both generators.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      GEN_REG <= 5'h00;
      GEN_DATA <= 8'h00;
    end else if (WR) begin
      GEN_REG <= reg_idx;
      GEN_DATA <= WDATA;
    end
  end

  // Real chip writes. A right-channel write without an active second chip is dropped,
  // because forwarding it would overwrite the left channel in the only chip.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CHIP0_WR <= 1'b0;
      CHIP1_WR <= 1'b0;
    end else begin
      CHIP0_WR <= left_wr;
      CHIP1_WR <= right_to_chip;
    end
  end

  // A second chip wired to an expansion select line sees only its own writes there.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      FIRST_EXPANSION_IO_SELECT <= 1'b0;
      SECOND_EXPANSION_IO_SELECT <= 1'b0;
    end else begin
      FIRST_EXPANSION_IO_SELECT <= right_to_chip && (phys_code == PHYS_DE00);
      SECOND_EXPANSION_IO_SELECT <= right_to_chip && (phys_code == PHYS_DF00);
    end
  end

  // The address is translated even for a dropped right write; only the pulse is held back.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CHIP_ADDR <= 16'h0000;
      CHIP_DATA <= 8'h00;
    end else if (left_wr) begin
      CHIP_ADDR <= {PAGE_D4[15:5], reg_idx};
      CHIP_DATA <= WDATA;
    end else if (right_wr) begin
      CHIP_ADDR <= {phys_base[15:5], reg_idx};
      CHIP_DATA <= WDATA;
    end
  end

  // Audio mapping. The left output always follows the first generator.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AUDIO_LEFT <= '0;
    end else begin
      AUDIO_LEFT <= GEN0_SAMPLE;
    end
  end

  // In mono the first generator is copied to the right output as well.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AUDIO_RIGHT <= '0;
    end else begin
      AUDIO_RIGHT <= emu_stereo ? GEN1_SAMPLE : GEN0_SAMPLE;
    end
  end

  assign CFG = sound_emulation_config;
endmodule // sscar_router

// file: test/sscar_router_sva.sv
// Concurrent checks on the sound router's ports.
`timescale 1ns/1ps
module sscar_router_sva
  import sscar_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input wire logic CLK, // Clock.
  input wire logic RESET, // Reset, active high.
  input wire logic WR, // Write strobe.
  input wire logic RD, // Read strobe.
  input wire logic CFG_MODE, // Configuration visible.
  input wire logic D7_AREA_ON, // Memory owns D7xx.
  input wire logic CART_IO1_ON, // Cartridge owns DExx.
  input wire logic [15:0] ADDR, // Host address.
  input wire logic [15:0] CHIP_ADDR, // Chip address.
  input wire logic [7:0] WDATA, // Write data.
  input wire logic [7:0] RDATA, // Read data.
  input wire logic [7:0] CFG, // Configuration.
  input wire logic RDATA_VALID, // Read valid.
  input wire logic GEN0_WR, // First generator write.
  input wire logic GEN1_WR, // Second generator write.
  input wire logic CHIP0_WR, // First chip write.
  input wire logic CHIP1_WR, // Second chip write.
  input wire logic FIRST_EXPANSION_IO_SELECT, // Select line.
  input wire logic [4:0] GEN_REG, // Register index.
  input wire logic [SAMPLE_W-1:0] GEN0_SAMPLE, // First audio in.
  input wire logic [SAMPLE_W-1:0] GEN1_SAMPLE, // Second audio in.
  input wire logic [SAMPLE_W-1:0] AUDIO_LEFT, // Left audio out.
  input wire logic [SAMPLE_W-1:0] AUDIO_RIGHT // Right audio out.
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  chk_mono_right: assert property (!$past(RESET) && $past(CFG[2:0]) == 3'h0 |->
    AUDIO_RIGHT == $past(GEN0_SAMPLE)) else $error("mono right wrong");
  chk_left_first: assert property (!$past(RESET) |->
    AUDIO_LEFT == $past(GEN0_SAMPLE)) else $error("left wrong");
  chk_stereo_right: assert property (!$past(RESET) && $past(CFG[2:0]) inside
    {3'h1, 3'h4, 3'h5, 3'h6, 3'h7} |-> AUDIO_RIGHT == $past(GEN1_SAMPLE)) else $error("right wrong");
  chk_no_chip1: assert property ($past(CFG[5:3]) inside {3'h0, 3'h2, 3'h3} |->
    !CHIP1_WR) else $error("second chip written");
  chk_chip_pairs: assert property (CHIP0_WR == GEN0_WR && (!CHIP1_WR || GEN1_WR))
    else $error("chip pulse unpaired");
  chk_chip1_d420: assert property (CHIP1_WR && $past(CFG[5:3]) == 3'h1 |->
    CHIP_ADDR == (BASE_D420 | {11'h000, GEN_REG})) else $error("chip address wrong");
  chk_io1_select: assert property (FIRST_EXPANSION_IO_SELECT ==
    (CHIP1_WR && $past(CFG[5:3]) == 3'h6)) else $error("select wrong");
  chk_cart_wins: assert property (WR && CART_IO1_ON && ADDR[15:8] == 8'hDE |=>
    !GEN1_WR) else $error("cartridge lost");
  chk_d7_wins: assert property (WR && D7_AREA_ON && ADDR[15:8] == 8'hD7 |=>
    !GEN1_WR && !GEN0_WR) else $error("memory area lost");
  chk_cfg_write: assert property (WR && CFG_MODE && ADDR == CFG_ADDR |=>
    CFG == $past(WDATA)) else $error("config not stored");
  chk_read_back: assert property (RD && CFG_MODE && ADDR == CFG_ADDR |=>
    RDATA_VALID && RDATA == $past(CFG)) else $error("read back wrong");
  cover property (CHIP1_WR && FIRST_EXPANSION_IO_SELECT);
  cover property (GEN1_WR && CFG[2:0] == 3'h1);
  cover property (RDATA_VALID);
endmodule // sscar_router_sva
bind sscar_router sscar_router_sva #(.SAMPLE_W(SAMPLE_W)) sscar_router_sva_inst (.CLK, .RESET,
  .WR, .RD, .CFG_MODE, .D7_AREA_ON, .CART_IO1_ON, .ADDR, .CHIP_ADDR, .WDATA, .RDATA, .CFG,
  .RDATA_VALID, .GEN0_WR, .GEN1_WR, .CHIP0_WR, .CHIP1_WR, .FIRST_EXPANSION_IO_SELECT, .GEN_REG,
  .GEN0_SAMPLE, .GEN1_SAMPLE, .AUDIO_LEFT, .AUDIO_RIGHT);

// file: test/sscar_chip_model.sv
// Behavioural model of one real sound chip strapped to a fixed bus page.
`timescale 1ns/1ps
module sscar_chip_model #(
  parameter logic [15:0] BASE = 16'hD400
) (
  input wire logic clk, // Host bus clock.
  input wire logic wr, // Write pulse from the router.
  input wire logic [15:0] addr, // Chip bus address.
  output logic [15:0] taken // Writes that decoded here.
);
  initial taken = 16'h0000;
  // A mistranslated address simply misses the chip, as on a real board.
  always @(posedge clk) begin
    if (wr && addr[15:5] == BASE[15:5]) begin
      taken <= taken + 16'h0001;
    end
  end
endmodule // sscar_chip_model

// file: test/tb_top.sv
// Self-checking bench for the sound router with two real chips attached.
`timescale 1ns/1ps
module tb_top;
  import sscar_pkg::*;
  logic CLK = 0, RESET = 1, WR = 0, RD = 0, CFG_MODE = 1, wr_d = 0;
  logic D7_AREA_ON = 0, CART_IO1_ON = 0, CART_IO2_ON = 0;
  logic [15:0] ADDR = 16'h0000, GEN0_SAMPLE = 16'h0000, GEN1_SAMPLE = 16'h0000;
  logic [15:0] CHIP_ADDR, AUDIO_LEFT, AUDIO_RIGHT, t0, t1;
  logic [7:0] WDATA = 8'h00, RDATA, CFG, GEN_DATA, CHIP_DATA, cfg = 8'h00;
  logic [4:0] GEN_REG;
  logic RDATA_VALID, GEN0_WR, GEN1_WR, CHIP0_WR, CHIP1_WR;
  logic FIRST_EXPANSION_IO_SELECT, SECOND_EXPANSION_IO_SELECT;
  logic [31:0] seed = 32'h566E, aud = 32'h566E;
  logic [2:0] flags = 3'h0;
  logic [35:0] qw[$];
  logic [7:0] qr[$];
  // Codes without a fitted chip still translate to the D420 page; only the pulse is held.
  logic [15:0] base [8] = '{BASE_D420, BASE_D420, BASE_D420, BASE_D420,
    PAGE_D5, PAGE_D7, PAGE_DE, PAGE_DF};
  logic [7:0] pages [8] = '{8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hDE, 8'hDF, 8'hD4, 8'hD0};
  int failures = 0, checks = 0, n0 = 0, n1 = 0, i, k;
  always #25 CLK = ~CLK;
  sscar_router sscar_router_inst (.CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .CFG_MODE, .D7_AREA_ON,
    .CART_IO1_ON, .CART_IO2_ON, .GEN0_SAMPLE, .GEN1_SAMPLE, .RDATA, .RDATA_VALID, .CFG, .GEN0_WR,
    .GEN1_WR, .GEN_REG, .GEN_DATA, .CHIP0_WR, .CHIP1_WR, .CHIP_ADDR, .CHIP_DATA,
    .FIRST_EXPANSION_IO_SELECT, .SECOND_EXPANSION_IO_SELECT, .AUDIO_LEFT, .AUDIO_RIGHT);
  sscar_chip_model #(.BASE(PAGE_D4)) chip0_inst (.clk(CLK), .wr(CHIP0_WR), .addr(CHIP_ADDR), .taken(t0));
  sscar_chip_model #(.BASE(PAGE_D5)) chip1_inst (.clk(CLK), .wr(CHIP1_WR), .addr(CHIP_ADDR), .taken(t1));
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [35:0] exp_wr(logic [7:0] c, logic [15:0] a, logic [7:0] d);
    logic snd, sec, fst, c1;
    snd = a[15:10] == 6'h35 && !(a[15:8] == 8'hD7 && flags[0]);
    case (c[2:0])
      3'h1: sec = snd && a[5];
      3'h4, 3'h5: sec = snd && a[8];
      3'h6: sec = a[15:8] == 8'hDE && !flags[1];
      3'h7: sec = a[15:8] == 8'hDF && !flags[2];
      default: sec = 1'b0;
    endcase
    fst = snd && !sec;
    c1 = sec && !(c[5:3] inside {3'h0, 3'h2, 3'h3});
    return {fst | sec, fst, sec, fst, c1, c1 && c[5:3] == 3'h6, c1 && c[5:3] == 3'h7,
      a[4:0], d, (sec ? base[c[5:3]] : PAGE_D4) | {11'h000, a[4:0]}};
  endfunction
  task automatic check(logic [28:0] seen, logic [28:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
    logic [35:0] e;
    @(posedge CLK);
    WR <= w;
    RD <= !w;
    ADDR <= a;
    WDATA <= d;
    e = exp_wr(cfg, a, d);
    n0 += e[32];
    n1 += e[31] && cfg[5:3] == 3'h4;
    if (w) qw.push_back(e);
    else if (CFG_MODE && a == CFG_ADDR) qr.push_back(cfg);
    if (w && CFG_MODE && a == CFG_ADDR) cfg = d;
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    aud <= xs(aud);
    {GEN1_SAMPLE, GEN0_SAMPLE} <= aud;
  end
  always @(posedge CLK) begin
    logic [35:0] e;
    if (wr_d) begin
      e = qw.pop_front();
      check({GEN0_WR, GEN1_WR, CHIP0_WR, CHIP1_WR, FIRST_EXPANSION_IO_SELECT,
        SECOND_EXPANSION_IO_SELECT}, e[34:29]);
      if (e[35]) check({GEN_REG, GEN_DATA, CHIP_ADDR}, e[28:0]);
      if (e[35]) check(CHIP_DATA, e[23:16]);
    end
    if (RDATA_VALID) check(RDATA, qr.size() > 0 ? qr.pop_front() : ~RDATA);
    wr_d <= WR;
  end
  // The walk needs about 2000 cycles; ten times that means the design hung.
  initial begin
    #1000000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    for (k = 0; k < 64; k++) begin
      seed = xs(seed);
      flags = seed[2:0] & seed[5:3];
      {CART_IO2_ON, CART_IO1_ON, D7_AREA_ON} <= flags;
      bus(1'b1, CFG_ADDR, {2'b00, k[5:0]});
      bus(1'b0, CFG_ADDR, 8'h00);
      for (i = 0; i < 12; i++) begin
        seed = xs(seed);
        bus(1'b1, {pages[seed[2:0]], seed[15:8]}, seed[23:16]);
      end
    end
    $display("routing walk done");
    CFG_MODE <= 1'b0;
    bus(1'b1, CFG_ADDR, 8'h3F);
    bus(1'b0, CFG_ADDR, 8'h00);
    CFG_MODE <= 1'b1;
    bus(1'b0, CFG_ADDR, 8'h00);
    bus(1'b0, 16'hD0F3, 8'h00);
    bus(1'b1, CFG_ADDR, 8'h21);
    bus(1'b1, 16'hD425, 8'h5A);
    bus(1'b1, CFG_ADDR, 8'h09);
    bus(1'b1, 16'hD43F, 8'hA5);
    repeat (3) @(posedge CLK);
    check(t0, n0[15:0]);
    check(t1, n1[15:0]);
    check(29'(qw.size()), 29'h0);
    check(29'(qr.size()), 29'h0);
    $display("config guard and chip tally done");
    stop_test();
  end
endmodule // tb_top
